// ### rtl/ledsr_pkg.sv
// Package for the LED driver serial load and error link.
// Assumes one 125 MHz system clock on both ends.
package ledsr_pkg;
  localparam int unsigned LEDSR_CHANNELS = 16;
  localparam int unsigned LEDSR_GS_BITS = 12;
  localparam int unsigned LEDSR_DC_BITS = 6;
  localparam int unsigned LEDSR_GS_FRAME = 192;
  localparam int unsigned LEDSR_DC_FRAME = 96;
  localparam int unsigned LEDSR_SR_LEN = 192;
  localparam logic [5:0] LEDSR_NV_DEFAULT = 6'h3_F;
  localparam logic [1:0] LEDSR_MODE_GS = 2'h0;
  localparam logic [1:0] LEDSR_MODE_DC = 2'h1;
  localparam logic [1:0] LEDSR_MODE_PROG = 2'h2;
  // Host register map (word index on the plain port)
  localparam logic [3:0] LEDSR_REG_CTRL = 4'h0;
  localparam logic [3:0] LEDSR_REG_DATA = 4'h1;
  localparam logic [3:0] LEDSR_REG_STAT = 4'h2;
  localparam logic [3:0] LEDSR_REG_RXDATA = 4'h3;
  localparam logic [3:0] LEDSR_REG_SIGS = 4'h4;
  localparam int unsigned LEDSR_CTRL_GO = 0;
  localparam int unsigned LEDSR_CTRL_DC = 1;
  localparam int unsigned LEDSR_CTRL_LATCH = 2;
  localparam int unsigned LEDSR_CTRL_PROG = 3;
  localparam int unsigned LEDSR_CTRL_SRCSEL = 4;
  localparam int unsigned LEDSR_CTRL_BLANK = 5;
  localparam int unsigned LEDSR_CLK_DIV = 8;
  typedef enum logic [4:0] {
    LEDSR_IDLE = 5'b00001,
    LEDSR_LOW = 5'b00010,
    LEDSR_HIGH = 5'b00100,
    LEDSR_LAT = 5'b01000,
    LEDSR_LATE = 5'b10000
  } ledsr_state_t;
endpackage

// ### rtl/ledsr_if.sv
// Pin bundle between host controller and LED driver.
// Wired-OR error line resolves from the device enable; pull-up assumed.
`timescale 1ns/10ps
interface ledsr_if;
  logic serial_clk;
  logic serial_data_in;
  logic serial_data_out;
  logic latch_strobe;
  logic [1:0] mode_select_pin;
  logic correction_source_select;
  logic blank;
  logic error_line_oe;
  logic error_line_o;
  // Open drain with external pull-up
  wire error_line = error_line_oe ? error_line_o : 1'b1;
  modport device (input serial_clk, serial_data_in, latch_strobe, mode_select_pin,
    correction_source_select, blank, output serial_data_out, error_line_oe, error_line_o);
  modport host (output serial_clk, serial_data_in, latch_strobe, mode_select_pin,
    correction_source_select, blank, input serial_data_out, error_line);
endinterface

// ### rtl/ledsr_device.sv
// LED driver device end: serial shift register, latches, error line.
// Assumes link pins asynchronous to clk; flags come from analog sense.
// How it works
// - Rising shift clock shifts data in
// - Strobe high copies to selected register
// - Host pulses strobe after full frame
// - Registers are level latches, not edges
// - Frames travel most significant bit first
// - Frame is 96 or 192 bits
// - Shifting never disturbs outputs before latch
// - Host latches grayscale at cycle end; ledsr_host strobes right after the frame, not timed to the grayscale counter
// - Latched grayscale applies immediately
// - Serial out feeds next chained device
// - Serial out returns status to host
// - Mode pin selects grayscale or correction
// - Programming voltage writes correction to storage; here only with source select on register
// - Error line low on any flag
// - System pulls error line up
// - Blanking masks open LED from error
// - Blanking forces outputs off, resets counter
// - Source select picks storage or register
// - Sixteen six-bit values loaded together
// - Open-LED bits captured on strobe fall
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/10ps
module ledsr_device (
  input wire logic clk,
  input wire logic rst_n,
  ledsr_if.device pins,
  input wire logic gs_clk_en,
  input wire logic [ledsr_pkg::LEDSR_CHANNELS-1:0] open_led_flag,
  input wire logic thermal_error_flag,
  output logic [ledsr_pkg::LEDSR_CHANNELS-1:0] channel_output,
  output logic [ledsr_pkg::LEDSR_CHANNELS*ledsr_pkg::LEDSR_DC_BITS-1:0] dot_correction,
  output logic [ledsr_pkg::LEDSR_CHANNELS*ledsr_pkg::LEDSR_GS_BITS-1:0] grayscale
);
  import ledsr_pkg::*;
  localparam int unsigned NCH = LEDSR_CHANNELS;
  localparam int unsigned DCW = NCH * LEDSR_DC_BITS;
  localparam int unsigned GSW = NCH * LEDSR_GS_BITS;

  // Two-stage synchronisers for link pins
  logic [5:0] s1_q, s2_q;
  logic sclk_d1_q, lat_d1_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      sclk_d1_q <= 1'b0;
      lat_d1_q <= 1'b0;
    end else begin
      s1_q <= {pins.serial_clk, pins.serial_data_in, pins.latch_strobe,
               pins.mode_select_pin, pins.correction_source_select};
      s2_q <= s1_q;
      sclk_d1_q <= s2_q[5];
      lat_d1_q <= s2_q[3];
    end
  end
  wire sclk_s = s2_q[5];
  wire sin_s = s2_q[4];
  wire lat_s = s2_q[3];
  wire [1:0] mode_s = s2_q[2:1];
  wire srcsel_s = s2_q[0];
  wire sclk_rise = sclk_s & ~sclk_d1_q;
  wire lat_fall = ~lat_s & lat_d1_q;
  wire blank_s;
  logic [1:0] bl_q;
  always_ff @(posedge clk) begin
    if (!rst_n) bl_q <= 2'b11;
    else bl_q <= {bl_q[0], pins.blank};
  end
  assign blank_s = bl_q[1];

  // Input shift register, MSB first; status loaded on strobe fall in grayscale mode
  logic [LEDSR_SR_LEN-1:0] sr_q;
  logic [NCH-1:0] status_q;
  wire mode_gs = (mode_s == LEDSR_MODE_GS);
  wire mode_dc = (mode_s == LEDSR_MODE_DC);
  // Last stage depends on frame length of the mode
  wire [7:0] last_idx = mode_dc ? 8'(LEDSR_DC_FRAME - 1) : 8'(LEDSR_GS_FRAME - 1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sr_q <= '0;
    end else if (sclk_rise) begin
      sr_q <= {sr_q[LEDSR_SR_LEN-2:0], sin_s};
    end else if (lat_fall && mode_gs) begin
      sr_q[LEDSR_SR_LEN-1 -: NCH] <= status_q;
    end
  end

  // Status capture of open-LED bits
  always_ff @(posedge clk) begin
    if (!rst_n) status_q <= '0;
    else if (lat_fall) status_q <= open_led_flag;
  end

  // Serial out registered from last stage
  logic serial_data_out_q;
  always_ff @(posedge clk) begin
    if (!rst_n) serial_data_out_q <= 1'b0;
    else serial_data_out_q <= sr_q[last_idx];
  end
  assign pins.serial_data_out = serial_data_out_q;

  // Level latches emulated: transparent every cycle strobe is high
  logic [GSW-1:0] gs_q;
  logic [DCW-1:0] dcreg_q;
  logic [DCW-1:0] nv_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gs_q <= '0;
      dcreg_q <= '0;
    end else if (lat_s) begin
      if (mode_gs) gs_q <= sr_q[GSW-1:0];
      else if (mode_dc) dcreg_q <= sr_q[DCW-1:0];
    end
  end

  // Nonvolatile storage, unprogrammed value all ones per channel
  always_ff @(posedge clk) begin
    if (!rst_n) nv_q <= {NCH{LEDSR_NV_DEFAULT}};
    else if (mode_s == LEDSR_MODE_PROG && srcsel_s) nv_q <= dcreg_q;
  end
  assign dot_correction = srcsel_s ? dcreg_q : nv_q;
  assign grayscale = gs_q;

  // Grayscale counter and channel PWM
  logic [LEDSR_GS_BITS-1:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!rst_n || blank_s) cnt_q <= '0;
    else if (gs_clk_en) cnt_q <= cnt_q + 1'b1;
  end
  logic [NCH-1:0] ch_q;
  genvar g;
  for (g = 0; g < NCH; g++) begin : g_ch
    always_ff @(posedge clk) begin
      if (!rst_n || blank_s) ch_q[g] <= 1'b0;
      else ch_q[g] <= (cnt_q < gs_q[g*LEDSR_GS_BITS +: LEDSR_GS_BITS]);
    end
  end
  assign channel_output = ch_q;

  // Open-drain error output
  logic err_q;
  always_ff @(posedge clk) begin
    if (!rst_n) err_q <= 1'b0;
    else err_q <= thermal_error_flag | ((|open_led_flag) & ~blank_s);
  end
  assign pins.error_line_oe = err_q;
  assign pins.error_line_o = 1'b0;
endmodule

// ### rtl/ledsr_host.sv
// Host controller end: shifts frames out, strobes latch, reads back.
// Assumes software on the plain register port, same clk as host.
`timescale 1ns/10ps
module ledsr_host #(
  parameter int unsigned DIV = ledsr_pkg::LEDSR_CLK_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  ledsr_if.host pins,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import ledsr_pkg::*;
  ledsr_state_t st_q, st_d;
  logic [31:0] ctrl_q;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic [7:0] bits_q;
  logic [15:0] div_q;
  logic sclk_q, sin_q, lat_q;
  logic [1:0] e1_q;
  logic [31:0] rdata_q;

  // Error line and serial out synchronised
  logic [1:0] so_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      e1_q <= 2'b11;
      so_q <= '0;
    end else begin
      e1_q <= {e1_q[0], pins.error_line};
      so_q <= {so_q[0], pins.serial_data_out};
    end
  end

  wire tick = (div_q == 16'(DIV/2 - 1));
  wire busy = (st_q != LEDSR_IDLE);
  // Frame length from the word that starts the transfer, not the old control
  wire [7:0] frame = wdata[LEDSR_CTRL_DC] ? 8'(LEDSR_DC_FRAME) : 8'(LEDSR_GS_FRAME);
  wire go = wr && addr == LEDSR_REG_CTRL && wdata[LEDSR_CTRL_GO] && !busy;
  wire txw = wr && addr == LEDSR_REG_DATA;

  // Transfer sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      LEDSR_IDLE: if (go) st_d = LEDSR_LOW;
      LEDSR_LOW: if (tick) st_d = LEDSR_HIGH;
      LEDSR_HIGH: if (tick) st_d = (bits_q == 8'd1) ? LEDSR_LAT : LEDSR_LOW;
      LEDSR_LAT: if (tick) st_d = LEDSR_LATE;
      LEDSR_LATE: if (tick) st_d = LEDSR_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= LEDSR_IDLE;
      div_q <= '0;
    end else begin
      st_q <= st_d;
      div_q <= (!busy || tick) ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // Control, bit counter and shift data, MSB first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= '0;
      bits_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      sclk_q <= 1'b0;
      sin_q <= 1'b0;
      lat_q <= 1'b0;
    end else begin
      if (wr && addr == LEDSR_REG_CTRL && !busy) ctrl_q <= wdata;
      if (go) bits_q <= frame;
      if (txw) tx_q <= wdata;
      if (st_q == LEDSR_LOW && tick) begin
        sin_q <= tx_q[31];
        tx_q <= {tx_q[30:0], 1'b0};
        sclk_q <= 1'b1;
        rx_q <= {rx_q[30:0], so_q[1]};
      end
      if (st_q == LEDSR_HIGH && tick) begin
        sclk_q <= 1'b0;
        bits_q <= bits_q - 8'd1;
      end
      lat_q <= (st_q == LEDSR_LAT) && ctrl_q[LEDSR_CTRL_LATCH];
    end
  end

  assign pins.serial_clk = sclk_q;
  assign pins.serial_data_in = sin_q;
  assign pins.latch_strobe = lat_q;
  assign pins.mode_select_pin = ctrl_q[LEDSR_CTRL_PROG] ? LEDSR_MODE_PROG :
    (ctrl_q[LEDSR_CTRL_DC] ? LEDSR_MODE_DC : LEDSR_MODE_GS);
  assign pins.correction_source_select = ctrl_q[LEDSR_CTRL_SRCSEL];
  assign pins.blank = ctrl_q[LEDSR_CTRL_BLANK];

  // Read mux, data one cycle later
  wire [31:0] rmux = (addr == LEDSR_REG_CTRL) ? ctrl_q :
    (addr == LEDSR_REG_STAT) ? {23'h0, bits_q, busy} :
    (addr == LEDSR_REG_RXDATA) ? rx_q :
    (addr == LEDSR_REG_SIGS) ? {31'h0, ~e1_q[1]} : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (!rst_n) rdata_q <= '0;
    else if (rd) rdata_q <= rmux;
  end
  assign rdata = rdata_q;
endmodule

// ### verif/ledsr_properties.sv
// Checker for the link between host controller and LED driver.
// Assumes plain copies of the bundle pins and of the device flag ports.
`timescale 1ns/10ps
module ledsr_properties (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic serial_data_out,
  input wire logic latch_strobe,
  input wire logic [1:0] mode_select_pin,
  input wire logic correction_source_select,
  input wire logic blank,
  input wire logic error_line_oe,
  input wire logic thermal_error_flag,
  input wire logic [ledsr_pkg::LEDSR_CHANNELS-1:0] open_led_flag,
  input wire logic [ledsr_pkg::LEDSR_DC_FRAME-1:0] dot_correction,
  input wire logic [ledsr_pkg::LEDSR_GS_FRAME-1:0] grayscale
);
  import ledsr_pkg::*;
  logic sclk_q, strb_q;
  logic [1:0] mode_q;
  logic [3:0] since_q;
  wire cause = (serial_clk & ~sclk_q) | (~latch_strobe & strb_q) | (mode_select_pin != mode_q);
  // Cycles since the last event allowed to move the serial output
  always_ff @(posedge clk) begin
    sclk_q <= serial_clk;
    strb_q <= latch_strobe;
    mode_q <= mode_select_pin;
    if (!rst_n || cause) begin
      since_q <= 4'h0;
    end else if (since_q != 4'hF) begin
      since_q <= since_q + 4'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_err_thermal: assert property (thermal_error_flag [*6] |-> error_line_oe)
    else $error("error line released under thermal error");
  a_err_open: assert property ((open_led_flag != '0 && !blank) [*6] |-> error_line_oe)
    else $error("error line released under open led");
  a_err_idle: assert property ((!thermal_error_flag && open_led_flag == '0) [*6] |-> !error_line_oe)
    else $error("error line pulled without a flag");
  a_err_masked: assert property ((blank && !thermal_error_flag) [*6] |-> !error_line_oe)
    else $error("open led not masked by blanking");
  a_gs_hold: assert property ((!latch_strobe) [*8] |-> $stable(grayscale))
    else $error("grayscale moved with strobe low");
  a_dc_hold: assert property ((!latch_strobe && correction_source_select) [*8] |-> $stable(dot_correction))
    else $error("correction moved with strobe low");
  a_serial_data_out_cause: assert property ($changed(serial_data_out) |-> since_q <= 4'h7)
    else $error("serial output moved without a shift");
  a_strobe_idle: assert property ($rose(latch_strobe) |-> !serial_clk)
    else $error("strobe raised with shift clock high");
  a_strobe_pulse: assert property ($rose(latch_strobe) |-> latch_strobe [*3] ##[1:3] !latch_strobe)
    else $error("strobe pulse width wrong");
  c_latch: cover property ($fell(latch_strobe));
  c_err: cover property ($rose(error_line_oe));
  c_dc_load: cover property (latch_strobe && mode_select_pin == LEDSR_MODE_DC);
endmodule

// ### verif/testbench.sv
// Testbench joining host controller and LED driver over one pin bundle.
// Assumes the default divider; software drives the host register port.
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_compared++; if ((a) !== (b)) begin errors++; $display("mismatch at %0t: %s", $time, m); end end
module testbench;
  import ledsr_pkg::*;
  localparam logic [31:0] GO = 32'h0000_0001;
  localparam logic [31:0] DC = 32'h0000_0002;
  localparam logic [31:0] LAT = 32'h0000_0004;
  localparam logic [31:0] PROG = 32'h0000_0008;
  localparam logic [31:0] SRC = 32'h0000_0010;
  localparam logic [31:0] BLK = 32'h0000_0020;
  localparam logic [95:0] F1 = 96'h0123_4567_89AB_CDEF_FEDC_BA98;
  localparam logic [191:0] F2 = {4{48'h1357_9BDF_2468}};
  logic clk, rst_n, wr, rd, gs_clk_en, thermal_error_flag;
  logic [3:0] addr;
  logic [31:0] wdata, rdata, rv;
  logic [15:0] open_led_flag, channel_output;
  logic [95:0] dot_correction;
  logic [191:0] grayscale;
  int errors, n_compared;
  ledsr_if u_ledsr_if();
  ledsr_host u_ledsr_host (.clk(clk), .rst_n(rst_n), .pins(u_ledsr_if), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ledsr_device u_ledsr_device (.clk(clk), .rst_n(rst_n), .pins(u_ledsr_if),
    .gs_clk_en(gs_clk_en), .open_led_flag(open_led_flag),
    .thermal_error_flag(thermal_error_flag), .channel_output(channel_output),
    .dot_correction(dot_correction), .grayscale(grayscale));
  ledsr_properties u_ledsr_properties (.clk(clk), .rst_n(rst_n),
    .serial_clk(u_ledsr_if.serial_clk), .serial_data_out(u_ledsr_if.serial_data_out),
    .latch_strobe(u_ledsr_if.latch_strobe), .mode_select_pin(u_ledsr_if.mode_select_pin),
    .correction_source_select(u_ledsr_if.correction_source_select),
    .blank(u_ledsr_if.blank), .error_line_oe(u_ledsr_if.error_line_oe),
    .thermal_error_flag(thermal_error_flag), .open_led_flag(open_led_flag),
    .dot_correction(dot_correction), .grayscale(grayscale));
  // Clock and grayscale counter tick
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) gs_clk_en <= ~gs_clk_en;
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Shift n words MSB first; refill after the last bit of a word leaves
  task automatic send(input logic [31:0] ctrl, input int n, input logic [191:0] f);
    int k;
    int t;
    wr_reg(LEDSR_REG_DATA, f[191 -: 32]);
    wr_reg(LEDSR_REG_CTRL, ctrl | GO);
    for (k = 1; k <= n; k++) begin
      for (t = 0; t < 3000; t++) begin
        rd_reg(LEDSR_REG_STAT, rv);
        if (k < n ? rv[8:1] === 8'(32 * (n - k) + 1) : rv[0] === 1'b0) break;
      end
      `CHK(t < 3000, 1'b1, "frame stalled")
      // Wait out the shift of the word's last bit, land before the next one
      if (k < n) repeat (4) @(posedge clk);
      if (k < n) wr_reg(LEDSR_REG_DATA, f[191 - 32 * k -: 32]);
    end
    repeat (8) @(posedge clk);
  endtask
  // Watchdog against a hung frame
  initial begin
    #(8 * 40000);
    errors++;
    summarize();
  end
  initial begin
    {rst_n, wr, rd, gs_clk_en, thermal_error_flag} = 5'h00;
    {addr, wdata, open_led_flag} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    send(DC | LAT | SRC, 3, {F1, 96'h0});
    `CHK(dot_correction, F1, "correction frame")
    wr_reg(LEDSR_REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge clk);
    `CHK(dot_correction, {16{LEDSR_NV_DEFAULT}}, "store default")
    wr_reg(LEDSR_REG_CTRL, PROG | SRC);
    repeat (16) @(posedge clk);
    wr_reg(LEDSR_REG_CTRL, 32'h0000_0000);
    repeat (8) @(posedge clk);
    `CHK(dot_correction, F1, "store programmed")
    $display("test correction done");
    send(LAT | SRC, 6, F2);
    `CHK(grayscale, F2, "grayscale frame")
    `CHK(dot_correction, F1, "correction kept")
    send(SRC, 6, ~F2);
    `CHK(grayscale, F2, "grayscale held unlatched")
    rd_reg(LEDSR_REG_RXDATA, rv);
    `CHK(rv, F2[31:0], "chained readback")
    $display("test grayscale done");
    thermal_error_flag <= 1'b1;
    repeat (8) @(posedge clk);
    `CHK(u_ledsr_if.error_line, 1'b0, "thermal error")
    rd_reg(LEDSR_REG_SIGS, rv);
    `CHK(rv[0], 1'b1, "error seen")
    thermal_error_flag <= 1'b0;
    open_led_flag <= 16'h0004;
    wr_reg(LEDSR_REG_CTRL, SRC | BLK);
    repeat (8) @(posedge clk);
    `CHK(u_ledsr_if.error_line, 1'b1, "open led masked")
    `CHK(channel_output, 16'h0000, "blanked outputs")
    wr_reg(LEDSR_REG_CTRL, SRC);
    repeat (8) @(posedge clk);
    `CHK(u_ledsr_if.error_line, 1'b0, "open led error")
    open_led_flag <= 16'h0000;
    repeat (8) @(posedge clk);
    `CHK(u_ledsr_if.error_line, 1'b1, "error released")
    $display("test error line done");
    summarize();
  end
endmodule
